// >>> inc/link_csr_pkg.sv
// Constants for the link control and status word and its timeout counter.
// Assumes a 16-bit host data path and a 125 MHz system clock.
package link_csr_pkg;

    // ----------
    // Word layout
    // ----------
    localparam int unsigned WORD_WIDTH = 16;
    localparam int unsigned BIT_TX_RING_DISABLE = 13;
    localparam int unsigned BIT_RX_RING_DISABLE = 12;
    localparam int unsigned BIT_TX_RING_ACTIVE = 11;
    localparam int unsigned BIT_RX_RING_ACTIVE = 10;
    localparam int unsigned BIT_IRQ_ENABLE = 9;
    localparam int unsigned BIT_IRQ_FLAG = 8;
    localparam int unsigned BIT_BUS_TIMEOUT = 7;
    localparam int unsigned BIT_LOST_FRAME = 6;
    localparam int unsigned BIT_RX_OVERRUN = 5;
    localparam int unsigned BIT_TX_UNDERRUN = 4;
    localparam int unsigned BIT_PRIMITIVE_EVENT = 3;
    localparam int unsigned BIT_TX_RING_EVENT = 2;
    localparam int unsigned BIT_RX_RING_EVENT = 1;
    localparam int unsigned BIT_ALWAYS_ZERO = 0;

    // Event flags held in bits 7 down to 1
    localparam int unsigned EVENT_COUNT = 7;
    localparam int unsigned EVENT_LSB = 1;

    // ----------
    // Reset values
    // ----------
    localparam logic RESET_RING_DISABLE = 1'h0;
    localparam logic RESET_POWER_OFF = 1'h1;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ----------
    // Timing
    // ----------
    localparam int unsigned BUS_TIMEOUT_CLOCKS = 256;
    localparam int unsigned TIMEOUT_COUNT_WIDTH = 9;

endpackage

// >>> rtl/bus_timeout_counter.sv
// Bus master ready watchdog: counts system clocks from address drive.
// Assumes ready_in is already synchronised to clk_in.
`timescale 1ns/1ps

module bus_timeout_counter #(
    parameter int unsigned LIMIT = link_csr_pkg::BUS_TIMEOUT_CLOCKS,
    parameter int unsigned COUNT_WIDTH = link_csr_pkg::TIMEOUT_COUNT_WIDTH
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic master_in,
    input wire logic address_start_in,
    input wire logic ready_in,
    output logic timeout_out
);

    localparam logic [COUNT_WIDTH-1:0] LAST = COUNT_WIDTH'(LIMIT - 1);

    logic [COUNT_WIDTH-1:0] count_q;
    logic waiting_q;

    // ----------
    // Wait window
    // ----------
    // A new address restarts the window; ready or losing mastership ends it
    always_ff @(posedge clk_in) begin
        if (reset_in || !master_in) begin
            waiting_q <= 1'h0;
            count_q <= '0;
        end else if (address_start_in) begin
            waiting_q <= 1'h1;
            count_q <= '0;
        end else if (ready_in || (waiting_q && count_q == LAST)) begin
            waiting_q <= 1'h0;
            count_q <= '0;
        end else if (waiting_q) begin
            count_q <= count_q + COUNT_WIDTH'(1);
        end
    end

    // [RULE10] Ready missing too long
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            timeout_out <= 1'h0;
        end else begin
            timeout_out <= master_in && waiting_q && !ready_in &&
                !address_start_in && count_q == LAST;
        end
    end

endmodule

// >>> rtl/link_ctrl_status_irq.sv
// Control and status word of the signalling link controller, with the
// sticky event flags and the active-low interrupt pin.
// Assumes the host register port has already selected this word; event
// strobes come from link logic on clk_in, bus ready comes from a pin.
`timescale 1ns/1ps

// Operation
// [RULE1] Receive ring disable: finish current unit, then accept nothing more.
// [RULE2] Transmit ring active sets at power-on or later when disable clears.
// [RULE3] Transmit ring active clears on disable, power-off or reset; read-only.
// [RULE4] Host rewrites transmit descriptors only while transmit ring inactive.
// [RULE5] Receive ring active sets at power-on or later when disable clears.
// [RULE6] Receive ring active clears on disable, power-off or reset; read-only.
// [RULE7] Interrupt pin low only when enable and interrupt flag both one.
// [RULE8] Interrupt enable clears on zero, reset, power-off; not settable then.
// [RULE9] Interrupt flag is OR of five event flags; cleared with them.
// [RULE10] Bus timeout flag sets if ready missing 256 clocks after address.
// [RULE11] Bus timeout releases bus and stops receiver and transmitter.
// [RULE12] Lost frame flag sets when a unit is dropped for lack of buffer.
// [RULE13] Receive overrun flag sets on full FIFO; unit being received dropped.
// [RULE14] Transmit underrun mid unit aborts the unit and sets its flag.
// [RULE15] Primitive event flag sets after a provider primitive is written.
// [RULE16] Transmit ring event flag sets after a transmit descriptor update.
// [RULE17] Receive ring event flag sets after a receive descriptor update.
// [RULE18] Event flags clear on written one, reset or power-off primitive.
// [RULE19] Bit zero is read-only and always reads zero.
// [RULE20] Transmit ring disable stops ring access after the current unit.
// [RULE21] Power-off primitive stops DMA, sends all ones, ignores received data.
// [RULE22] Power-on primitive accepted only in power-off; enters out of service.
// [RULE23] Set beats simultaneous clear; interrupt pin driven from a register.
module link_ctrl_status_irq #(
    parameter int unsigned TIMEOUT_CLOCKS = link_csr_pkg::BUS_TIMEOUT_CLOCKS
) (
    input wire logic clk_in,
    input wire logic reset_in,
    // Host access to the word
    input wire logic word_write_in,
    input wire logic word_read_in,
    input wire logic [15:0] word_wdata_in,
    output logic [15:0] word_rdata_out,
    // Primitive commands from the primitive decoder
    input wire logic power_off_cmd_in,
    input wire logic power_on_cmd_in,
    // Link engine state and events
    input wire logic rx_unit_busy_in,
    input wire logic tx_unit_busy_in,
    input wire logic rx_frame_dropped_in,
    input wire logic rx_fifo_full_store_in,
    input wire logic tx_empty_mid_unit_in,
    input wire logic provider_primitive_written_in,
    input wire logic tx_desc_updated_in,
    input wire logic rx_desc_updated_in,
    // Bus master timing
    input wire logic bus_master_in,
    input wire logic address_driven_in,
    input wire logic bus_ready_in,
    // Controls back to the engines
    output logic rx_ring_active_out,
    output logic tx_ring_active_out,
    output logic rx_accept_out,
    output logic dma_enable_out,
    output logic bus_release_out,
    output logic rx_discard_unit_out,
    output logic tx_abort_unit_out,
    output logic tx_send_ones_out,
    output logic power_off_out,
    output logic irq_n_out
);

    // ----------
    // Declarations
    // ----------
    localparam int unsigned NEV = link_csr_pkg::EVENT_COUNT;
    localparam int unsigned ELSB = link_csr_pkg::EVENT_LSB;

    logic power_off_q;
    logic rx_ring_disable_q;
    logic tx_ring_disable_q;
    logic rx_ring_active_q;
    logic tx_ring_active_q;
    logic irq_enable_q;
    logic irq_flag_q;
    logic [NEV-1:0] event_q;
    logic [NEV-1:0] event_d;
    logic [NEV-1:0] event_set;
    logic [NEV-1:0] event_clear;
    logic [2:0] ready_sync_q;
    logic ready_filt_q;
    logic bus_timeout;
    logic power_off_now;
    logic power_on_ok;
    logic [15:0] word_view;

    // Host write of a one to a given bit
    function automatic logic wrote_one(input logic [15:0] data,
                                       input int unsigned pos);
        wrote_one = data[pos];
    endfunction

    // Flags that reach the interrupt flag
    function automatic logic any_irq_cause(input logic [NEV-1:0] ev);
        any_irq_cause = ev[link_csr_pkg::BIT_BUS_TIMEOUT - ELSB] |
            ev[link_csr_pkg::BIT_LOST_FRAME - ELSB] |
            ev[link_csr_pkg::BIT_PRIMITIVE_EVENT - ELSB] |
            ev[link_csr_pkg::BIT_TX_RING_EVENT - ELSB] |
            ev[link_csr_pkg::BIT_RX_RING_EVENT - ELSB];
    endfunction

    // [RULE21] Power-off primitive
    assign power_off_now = power_off_cmd_in;
    // [RULE22] Power-on only from power-off
    assign power_on_ok = power_on_cmd_in && power_off_q && !power_off_cmd_in;

    // ----------
    // Bus ready synchroniser
    // ----------
    // The pin is asynchronous to clk_in; a change counts only once the
    // second and third stages agree, which also rejects one-stage glitches
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ready_sync_q <= 3'h0;
            ready_filt_q <= 1'h0;
        end else begin
            ready_sync_q <= {ready_sync_q[1:0], bus_ready_in};
            if (ready_sync_q[1] == ready_sync_q[2]) begin
                ready_filt_q <= ready_sync_q[2];
            end
        end
    end

    // [RULE10] Ready watchdog
    bus_timeout_counter #(
        .LIMIT(TIMEOUT_CLOCKS),
        .COUNT_WIDTH(link_csr_pkg::TIMEOUT_COUNT_WIDTH)
    ) u_timeout (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .master_in(bus_master_in),
        .address_start_in(address_driven_in),
        .ready_in(ready_filt_q),
        .timeout_out(bus_timeout)
    );

    // ----------
    // Power phase
    // ----------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            power_off_q <= link_csr_pkg::RESET_POWER_OFF;
        end else if (power_off_now) begin
            power_off_q <= 1'h1;
        end else if (power_on_ok) begin
            // [RULE22] Leave power-off phase
            power_off_q <= 1'h0;
        end
    end

    // ----------
    // Ring disable controls
    // ----------
    // A bus timeout turns both sides off by raising both disables, so
    // software must clear them deliberately before rings restart
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_ring_disable_q <= link_csr_pkg::RESET_RING_DISABLE;
            tx_ring_disable_q <= link_csr_pkg::RESET_RING_DISABLE;
        end else if (bus_timeout) begin
            // [RULE11] Stop receiver and transmitter
            rx_ring_disable_q <= 1'h1;
            tx_ring_disable_q <= 1'h1;
        end else if (word_write_in) begin
            rx_ring_disable_q <=
                wrote_one(word_wdata_in, link_csr_pkg::BIT_RX_RING_DISABLE);
            tx_ring_disable_q <=
                wrote_one(word_wdata_in, link_csr_pkg::BIT_TX_RING_DISABLE);
        end
    end

    // ----------
    // Ring active indications
    // ----------
    // Disable is recognised only once no unit is in progress, so the unit
    // already under way is finished first
    always_ff @(posedge clk_in) begin
        if (reset_in || power_off_now) begin
            rx_ring_active_q <= 1'h0;
        end else if (rx_ring_disable_q) begin
            // [RULE6] Clear on recognised disable
            if (!rx_unit_busy_in) begin
                rx_ring_active_q <= 1'h0;
            end
        end else if (power_on_ok || !power_off_q) begin
            // [RULE5] Set at power-on or on disable clear
            rx_ring_active_q <= 1'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || power_off_now) begin
            tx_ring_active_q <= 1'h0;
        end else if (tx_ring_disable_q) begin
            // [RULE3] Clear on recognised disable
            // [RULE20] Only the unit in transmission completes
            if (!tx_unit_busy_in) begin
                tx_ring_active_q <= 1'h0;
            end
        end else if (power_on_ok || !power_off_q) begin
            // [RULE2] Set at power-on or on disable clear
            tx_ring_active_q <= 1'h1;
        end
    end

    // ----------
    // Interrupt enable
    // ----------
    always_ff @(posedge clk_in) begin
        if (reset_in || power_off_q || power_off_now) begin
            // [RULE8] Held clear in power-off
            irq_enable_q <= 1'h0;
        end else if (word_write_in) begin
            irq_enable_q <=
                wrote_one(word_wdata_in, link_csr_pkg::BIT_IRQ_ENABLE);
        end
    end

    // ----------
    // Sticky event flags
    // ----------
    always_comb begin
        event_set = '0;
        // [RULE10] Bus timeout flag
        event_set[link_csr_pkg::BIT_BUS_TIMEOUT - ELSB] = bus_timeout;
        // [RULE12] Lost frame flag
        event_set[link_csr_pkg::BIT_LOST_FRAME - ELSB] = rx_frame_dropped_in;
        // [RULE13] Receive overrun flag
        event_set[link_csr_pkg::BIT_RX_OVERRUN - ELSB] = rx_fifo_full_store_in;
        // [RULE14] Transmit underrun flag
        event_set[link_csr_pkg::BIT_TX_UNDERRUN - ELSB] = tx_empty_mid_unit_in;
        // [RULE15] Primitive event flag
        event_set[link_csr_pkg::BIT_PRIMITIVE_EVENT - ELSB] =
            provider_primitive_written_in;
        // [RULE16] Transmit ring event flag
        event_set[link_csr_pkg::BIT_TX_RING_EVENT - ELSB] = tx_desc_updated_in;
        // [RULE17] Receive ring event flag
        event_set[link_csr_pkg::BIT_RX_RING_EVENT - ELSB] = rx_desc_updated_in;
    end

    // [RULE18] Write one to clear
    assign event_clear = word_write_in ?
        word_wdata_in[ELSB +: NEV] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_event
            // [RULE23] Set wins over clear
            always_comb begin
                event_d[gi] = event_set[gi] |
                    (event_q[gi] & ~event_clear[gi]);
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (reset_in || power_off_now) begin
            // [RULE18] Cleared on reset and power-off
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    // ----------
    // Interrupt flag and pin
    // ----------
    always_ff @(posedge clk_in) begin
        if (reset_in || power_off_now) begin
            irq_flag_q <= 1'h0;
        end else begin
            // [RULE9] OR of the interrupt causes
            irq_flag_q <= any_irq_cause(event_d);
        end
    end

    // Registered pin lags the flag by one clock but never glitches
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_n_out <= 1'h1;
        end else begin
            // [RULE7] Low only with enable and flag
            irq_n_out <= !(irq_enable_q && irq_flag_q);
        end
    end

    // ----------
    // Read view
    // ----------
    always_comb begin
        word_view = link_csr_pkg::RESET_WORD;
        word_view[link_csr_pkg::BIT_TX_RING_DISABLE] = tx_ring_disable_q;
        word_view[link_csr_pkg::BIT_RX_RING_DISABLE] = rx_ring_disable_q;
        word_view[link_csr_pkg::BIT_TX_RING_ACTIVE] = tx_ring_active_q;
        word_view[link_csr_pkg::BIT_RX_RING_ACTIVE] = rx_ring_active_q;
        word_view[link_csr_pkg::BIT_IRQ_ENABLE] = irq_enable_q;
        word_view[link_csr_pkg::BIT_IRQ_FLAG] = irq_flag_q;
        word_view[ELSB +: NEV] = event_q;
        // [RULE19] Bit zero reads zero
        word_view[link_csr_pkg::BIT_ALWAYS_ZERO] = 1'h0;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            word_rdata_out <= link_csr_pkg::RESET_WORD;
        end else if (word_read_in) begin
            word_rdata_out <= word_view;
        end
    end

    // ----------
    // Engine controls
    // ----------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_ring_active_out <= 1'h0;
            tx_ring_active_out <= 1'h0;
            power_off_out <= link_csr_pkg::RESET_POWER_OFF;
            tx_send_ones_out <= link_csr_pkg::RESET_POWER_OFF;
            dma_enable_out <= 1'h0;
        end else begin
            rx_ring_active_out <= rx_ring_active_q;
            tx_ring_active_out <= tx_ring_active_q;
            power_off_out <= power_off_q;
            // [RULE21] All ones and no DMA in power-off
            tx_send_ones_out <= power_off_q;
            dma_enable_out <= !power_off_q && !power_off_now;
        end
    end

    // [RULE1] Accept units only while receive ring runs
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_accept_out <= 1'h0;
        end else begin
            rx_accept_out <= rx_ring_active_q && !power_off_q &&
                !(rx_ring_disable_q && !rx_unit_busy_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_release_out <= 1'h0;
            rx_discard_unit_out <= 1'h0;
            tx_abort_unit_out <= 1'h0;
        end else begin
            // [RULE11] Release the bus
            bus_release_out <= bus_timeout;
            // [RULE13] Drop the unit being received
            rx_discard_unit_out <= rx_fifo_full_store_in;
            // [RULE14] Abort the unit in transmission
            tx_abort_unit_out <= tx_empty_mid_unit_in;
        end
    end

endmodule

// >>> verification/link_csr_checker.sv
// Port-level assertions for the link control and status word.
// Assumes it is bound into every link_ctrl_status_irq instance.
`timescale 1ns/1ps

module link_csr_checker #(
    parameter int unsigned TIMEOUT_CLOCKS = 256
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic word_write_in,
    input wire logic [15:0] word_wdata_in,
    input wire logic [15:0] word_rdata_out,
    input wire logic power_off_cmd_in,
    input wire logic power_on_cmd_in,
    input wire logic rx_fifo_full_store_in,
    input wire logic tx_empty_mid_unit_in,
    input wire logic bus_master_in,
    input wire logic address_driven_in,
    input wire logic rx_ring_active_out,
    input wire logic tx_ring_active_out,
    input wire logic dma_enable_out,
    input wire logic bus_release_out,
    input wire logic rx_discard_unit_out,
    input wire logic tx_abort_unit_out,
    input wire logic tx_send_ones_out,
    input wire logic power_off_out,
    input wire logic irq_n_out
);
    int unsigned cnt_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // ----------
    // Helpers
    // ----------
    // Clocks since the last address; losing the bus aborts the count
    always_ff @(posedge clk_in) begin
        if (reset_in || !bus_master_in) begin
            cnt_q <= 0;
        end else if (address_driven_in) begin
            cnt_q <= 1;
        end else if (cnt_q != 0 && cnt_q < 1000) begin
            cnt_q <= cnt_q + 1;
        end
    end

    sequence s_off_cmd;
        power_off_cmd_in ##1 1'b1;
    endsequence

    sequence s_on_taken;
        power_on_cmd_in && power_off_out && !power_off_cmd_in
            && !$past(power_on_cmd_in);
    endsequence

    // ----------
    // Assertions
    // ----------
    a_reset_outputs: assert property (
        $fell(reset_in) |-> irq_n_out && power_off_out
            && !tx_ring_active_out && !rx_ring_active_out)
        else $error("outputs wrong after reset");
    a_off_pin_high: assert property (
        power_off_out |-> irq_n_out)
        else $error("interrupt pin low in power-off");
    a_enable_zero_quiets: assert property (
        word_write_in && !word_wdata_in[9] |=> ##1 irq_n_out)
        else $error("interrupt pin low after enable cleared");
    a_send_ones: assert property (
        tx_send_ones_out == power_off_out
            && !(dma_enable_out && power_off_out))
        else $error("power-off outputs disagree");
    a_off_clears: assert property (
        s_off_cmd |=> power_off_out && !tx_ring_active_out
            && !rx_ring_active_out)
        else $error("power-off did not stop the rings");
    a_on_wakes: assert property (
        s_on_taken |=> ##1 !power_off_out)
        else $error("power-on did not leave power-off");
    a_release_time: assert property (
        $rose(bus_release_out) |-> cnt_q == TIMEOUT_CLOCKS + 2)
        else $error("bus release at wrong time");
    a_release_pulse: assert property (
        bus_release_out |=> !bus_release_out)
        else $error("bus release longer than one clock");
    a_discard_cause: assert property (
        $rose(rx_discard_unit_out) |-> $past(rx_fifo_full_store_in))
        else $error("discard without overrun");
    a_abort_cause: assert property (
        $rose(tx_abort_unit_out) |-> $past(tx_empty_mid_unit_in))
        else $error("abort without underrun");
    a_bit_zero: assert property (
        !word_rdata_out[0])
        else $error("bit zero read as one");
endmodule

bind link_ctrl_status_irq link_csr_checker #(
    .TIMEOUT_CLOCKS(TIMEOUT_CLOCKS)
) chk (
    .clk_in, .reset_in, .word_write_in, .word_wdata_in, .word_rdata_out,
    .power_off_cmd_in, .power_on_cmd_in, .rx_fifo_full_store_in,
    .tx_empty_mid_unit_in, .bus_master_in, .address_driven_in,
    .rx_ring_active_out, .tx_ring_active_out, .dma_enable_out,
    .bus_release_out, .rx_discard_unit_out, .tx_abort_unit_out,
    .tx_send_ones_out, .power_off_out, .irq_n_out
);

// >>> verification/host_model.sv
// Host processor model: one word access at a time on the strobes.
// Assumes the word port answers a read one clock after its edge.
`timescale 1ns/1ps

module host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic write_out,
    output logic read_out,
    output logic [15:0] wdata_out,
    output logic may_rewrite_out
);
    initial begin
        write_out = 1'b0;
        read_out = 1'b0;
        wdata_out = 16'h0000;
        may_rewrite_out = 1'b0;
    end

    // Released data is inverted so stale values never look valid
    task automatic write_word(input logic [15:0] d);
        @(posedge clk_in);
        write_out <= 1'b1;
        wdata_out <= d;
        @(posedge clk_in);
        write_out <= 1'b0;
        wdata_out <= ~d;
    endtask

    task automatic read_word(output logic [15:0] d);
        @(posedge clk_in);
        read_out <= 1'b1;
        @(posedge clk_in);
        read_out <= 1'b0;
        #1;
        d = rdata_in;
        may_rewrite_out <= !d[11];
    endtask
endmodule

// >>> verification/link_ctrl_status_irq_test.sv
// Self-checking bench for the control word, driven through host_model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps

module link_ctrl_status_irq_test;
    localparam int unsigned TO = 8;
    logic clk_in = 1'b0, reset_in = 1'b1;
    logic word_write_in, word_read_in;
    logic [15:0] word_wdata_in, word_rdata_out;
    logic power_off_cmd_in = 1'b0, power_on_cmd_in = 1'b0;
    logic rx_unit_busy_in = 1'b0, tx_unit_busy_in = 1'b0;
    logic bus_master_in = 1'b0, address_driven_in = 1'b0;
    logic bus_ready_in = 1'b0;
    logic [7:0] ev_q = 8'h00, seed = 8'h32;
    logic rx_ring_active_out, tx_ring_active_out, rx_accept_out;
    logic dma_enable_out, bus_release_out, rx_discard_unit_out;
    logic tx_abort_unit_out, tx_send_ones_out, power_off_out, irq_n_out;
    logic [7:0] fl = 8'h00;
    logic tx_ring_disable = 1'b0, rx_ring_disable = 1'b0, ton = 1'b0, ron = 1'b0, ien = 1'b0;
    logic poff = 1'b1;
    int n_mismatch = 0, n_checks = 0, n_rel = 0;

    always #4 clk_in = ~clk_in;

    link_ctrl_status_irq #(.TIMEOUT_CLOCKS(TO)) dut (
        .clk_in, .reset_in, .word_write_in, .word_read_in, .word_wdata_in,
        .word_rdata_out, .power_off_cmd_in, .power_on_cmd_in,
        .rx_unit_busy_in, .tx_unit_busy_in,
        .rx_frame_dropped_in(ev_q[6]), .rx_fifo_full_store_in(ev_q[5]),
        .tx_empty_mid_unit_in(ev_q[4]),
        .provider_primitive_written_in(ev_q[3]),
        .tx_desc_updated_in(ev_q[2]), .rx_desc_updated_in(ev_q[1]),
        .bus_master_in, .address_driven_in, .bus_ready_in,
        .rx_ring_active_out, .tx_ring_active_out, .rx_accept_out,
        .dma_enable_out, .bus_release_out, .rx_discard_unit_out,
        .tx_abort_unit_out, .tx_send_ones_out, .power_off_out, .irq_n_out
    );

    host_model host (
        .clk_in, .rdata_in(word_rdata_out), .write_out(word_write_in),
        .read_out(word_read_in), .wdata_out(word_wdata_in),
        .may_rewrite_out()
    );

    always @(posedge clk_in) if (bus_release_out === 1'b1) n_rel++;

    // ----------
    // Reference model and helpers
    // ----------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [15:0] exp_word();
        return {2'h0, tx_ring_disable, rx_ring_disable, ton, ron, ien, |(fl & 8'hCE), fl[7:1], 1'b0};
    endfunction

    // A disable takes effect only once the current unit has ended
    task automatic upd();
        ton = poff ? 1'b0 : !tx_ring_disable ? 1'b1 : tx_unit_busy_in ? ton : 1'b0;
        ron = poff ? 1'b0 : !rx_ring_disable ? 1'b1 : rx_unit_busy_in ? ron : 1'b0;
    endtask

    task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] d);
        host.write_word(d);
        ien = d[9] && !poff;
        tx_ring_disable = d[13];
        rx_ring_disable = d[12];
        fl = fl & ~(d[7:0] & 8'hFE);
        upd();
    endtask

    task automatic rd_chk();
        logic [15:0] v;
        host.read_word(v);
        check_val(v, exp_word());
        check_val({15'h0, irq_n_out}, {15'h0, !(ien && |(fl & 8'hCE))});
    endtask

    task automatic ev(input logic [7:0] m);
        @(posedge clk_in);
        ev_q <= m;
        @(posedge clk_in);
        ev_q <= 8'h00;
        fl = fl | (m & 8'h7E);
    endtask

    task automatic prim(input logic on);
        @(posedge clk_in);
        power_on_cmd_in <= on;
        power_off_cmd_in <= !on;
        @(posedge clk_in);
        power_on_cmd_in <= 1'b0;
        power_off_cmd_in <= 1'b0;
        if (!on) begin
            fl = 8'h00;
            ien = 1'b0;
        end
        poff = !on;
        upd();
    endtask

    task automatic addr_cycle();
        repeat (6) @(posedge clk_in);
        address_driven_in <= 1'b1;
        @(posedge clk_in);
        address_driven_in <= 1'b0;
        repeat (TO + 6) @(posedge clk_in);
    endtask

    // ----------
    // Scenarios
    // ----------
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk();
        wr(16'hFFFF);
        rd_chk();
        wr(16'h0000);
        prim(1'b1);
        rd_chk();
        check_val({15'h0, dma_enable_out}, 16'h0001);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            ev(seed);
            rd_chk();
            seed = lfsr(seed);
            wr({4'h0, seed[7:6], seed[5], 1'b1, seed});
            rd_chk();
        end
        // Set and clear of one flag in the same clock: set wins
        fork
            host.write_word(16'h0202);
            ev(8'h02);
        join
        ien = 1'b1;
        rd_chk();
        rx_unit_busy_in <= 1'b1;
        tx_unit_busy_in <= 1'b1;
        wr(16'h3200);
        rd_chk();
        rx_unit_busy_in <= 1'b0;
        tx_unit_busy_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        upd();
        rd_chk();
        check_val({15'h0, rx_accept_out}, 16'h0000);
        wr(16'h0200);
        rd_chk();
        check_val({15'h0, rx_accept_out}, 16'h0001);
        bus_master_in <= 1'b1;
        bus_ready_in <= 1'b1;
        addr_cycle();
        rd_chk();
        bus_ready_in <= 1'b0;
        addr_cycle();
        fl[7] = 1'b1;
        tx_ring_disable = 1'b1;
        rx_ring_disable = 1'b1;
        upd();
        rd_chk();
        check_val(n_rel[15:0], 16'h0001);
        wr(16'h0200);
        ev(8'h7E);
        prim(1'b0);
        rd_chk();
        check_val({14'h0, tx_send_ones_out, dma_enable_out}, 16'h0002);
        end_sim();
    end

    initial begin
        #(8 * 20000);
        n_mismatch++;
        end_sim();
    end
endmodule
